// ===== pkg/tsp_defines.vh
// Constants for the two-wire target serial port
// What this block does
// RQ1 - All target functions; general call address is never recognised or acknowledged.
// RQ2 - Four-bit mode select chooses 7/10-bit target, start/stop interrupts, or idle.
// RQ3 - When enabled in two-wire mode, pins driven only open-drain, if pins are inputs.
// RQ4 - After enable, wait for START then shift eight bits into byte shifter.
// RQ5 - Sample each incoming SDA bit on rising SCL.
// RQ6 - Compare shifter bits 7:1 with own address on eighth SCL falling edge.
// RQ7 - Match with flags clear: copy to buffer, set full, ack, flag on ninth fall.
// RQ8 - Full or overflow set: no copy, no ack, interrupt flag still set.
// RQ9 - Buffer read clears full flag; overflow clears only by software write.
// RQ10 - Ten-bit first byte is 11110, two address MSBs, write bit.
// RQ11 - After first ten-bit byte set flags, hold SCL; address write releases.
// RQ12 - After second ten-bit byte set flags again; matching address write releases.
// RQ13 - Ten-bit read after repeated START accepts high byte without address update.
// RQ14 - Matched address with write direction clears direction bit, buffers address.
// RQ15 - Interrupt flag set per data byte; software clears it and reads status.
// RQ16 - Matched address with read direction sets direction bit, acks, holds SCL.
// RQ17 - Buffer write in transmit loads shifter; SCL low until clock-release set.
// RQ18 - Transmit changes SDA on SCL falling edge, stable while SCL high.
// RQ19 - Ack latched on ninth rise; high ends transfer and resets, low continues.
// RQ20 - Controller waits while target stretches SCL low.
// RQ21 - Mode 0110 7-bit, 0111 10-bit, 1011 controller operation with target idle.
// RQ22 - Modes 1110 and 1111 add interrupt on START and STOP.
// RQ23 - Clock-release 0 holds SCL low; 1 releases it.
// RQ24 - Start and stop status bits record last condition; cleared on reset/disable.
// RQ25 - Disable returns to idle, releases pins, stops address matching.
`ifndef TSP_DEFINES_VH
`define TSP_DEFINES_VH
`define TSP_MODE_T7      4'h6
`define TSP_MODE_T10     4'h7
`define TSP_MODE_CTRL    4'hB
`define TSP_MODE_T7_SP   4'hE
`define TSP_MODE_T10_SP  4'hF
`define TSP_TEN_PREFIX   5'h1E
`define TSP_GENCALL      7'h00
`endif

// ===== rtl/tsp_sync.v
// Two-flop synchroniser with edge detection for a pin
`timescale 1ns/10ps
module tsp_sync (
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Pin in
  input  wire din,
  // Synchronised level and edges
  output wire lvl,
  output wire rise,
  output wire fall
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign lvl  = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule

// ===== rtl/tsp_target.v
// Two-wire serial port, target role
`timescale 1ns/10ps
`include "tsp_defines.vh"
module tsp_target (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst,
  // Bus pins
  input  wire       scl_in,
  output wire       scl_out,
  output wire       scl_oe,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  // Pin direction straps (1 = input)
  input  wire       scl_dir_in,
  input  wire       sda_dir_in,
  // Control
  input  wire       port_enable_bit,
  input  wire [3:0] port_mode_select,
  input  wire       clock_release_bit,
  input  wire       clock_release_wr,
  input  wire [7:0] own_address_register,
  input  wire       own_address_wr,
  input  wire [7:0] buf_wdata,
  input  wire       buf_wr,
  input  wire       buf_rd,
  input  wire       overflow_clr,
  input  wire       irq_clr,
  // Status
  output reg  [7:0] rx_tx_buffer,
  output reg        buffer_full_flag,
  output reg        receive_overflow_flag,
  output reg        port_interrupt_flag,
  output reg        address_update_needed,
  output reg        read_dir_flag,
  output reg        data_not_addr_flag,
  output reg        start_seen_flag,
  output reg        stop_seen_flag,
  output reg        clock_held
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX   = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_TX   = 5'h08;
  localparam [4:0] ST_TACK = 5'h10;

  wire scl_s, scl_rise, scl_fall, sda_s, sda_rise, sda_fall;
  tsp_sync u_scl (.mclk(mclk), .rst(rst), .din(scl_in), .lvl(scl_s), .rise(scl_rise),
                  .fall(scl_fall));
  tsp_sync u_sda (.mclk(mclk), .rst(rst), .din(sda_in), .lvl(sda_s), .rise(sda_rise),
                  .fall(sda_fall));

  function is_target;
    input [3:0] m;
    begin
      is_target = (m == `TSP_MODE_T7) || (m == `TSP_MODE_T10) ||
                  (m == `TSP_MODE_T7_SP) || (m == `TSP_MODE_T10_SP); // RQ21 RQ22
    end
  endfunction
  function is_ten;
    input [3:0] m;
    begin
      is_ten = (m == `TSP_MODE_T10) || (m == `TSP_MODE_T10_SP); // RQ2
    end
  endfunction

  wire tgt_mode = is_target(port_mode_select);
  wire any_mode = tgt_mode || (port_mode_select == `TSP_MODE_CTRL); // RQ21
  wire ten_mode = is_ten(port_mode_select);
  wire sp_irq   = port_mode_select[3] & port_mode_select[2] & port_mode_select[1]; // RQ22
  wire active   = port_enable_bit & tgt_mode; // RQ25
  // Start/stop: SDA moves while SCL high
  wire start_det = sda_fall & scl_s;
  wire stop_det  = sda_rise & scl_s;

  reg [4:0] st_r;
  reg [7:0] sh_r;
  reg [3:0] cnt_r;
  reg       addr_phase_r;
  reg       ten_lo_r;
  reg       ten_hi_ok_r;
  reg       acking_r;
  reg       sda_low_r;
  reg       hold_r;
  reg       ack_pend_r;
  reg [1:0] hi_bits_r;

  wire [7:0] byte_in = {sh_r[6:0], sda_s};
  // Ten-bit high byte, read or write
  wire hi_match = (sh_r[7:3] == `TSP_TEN_PREFIX) &&
                  (sh_r[2:1] == own_address_register[2:1]); // RQ10
  wire seven_match = (sh_r[7:1] == own_address_register[7:1]) &&
                     (sh_r[7:1] != `TSP_GENCALL); // RQ1 RQ6
  wire lo_match = (sh_r == own_address_register);
  // Restored high byte must carry the prefix and the A9:A8 seen on the bus
  wire hi_restore = (own_address_register[7:3] == `TSP_TEN_PREFIX) &&
                    (own_address_register[2:1] == hi_bits_r); // RQ12

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r                  <= ST_IDLE;
      sh_r                  <= 8'h00;
      cnt_r                 <= 4'h0;
      addr_phase_r          <= 1'b0;
      ten_lo_r              <= 1'b0;
      ten_hi_ok_r           <= 1'b0;
      acking_r              <= 1'b0;
      sda_low_r             <= 1'b0;
      hold_r                <= 1'b0;
      ack_pend_r            <= 1'b0;
      hi_bits_r             <= 2'h0;
      rx_tx_buffer          <= 8'h00;
      buffer_full_flag      <= 1'b0;
      receive_overflow_flag <= 1'b0;
      port_interrupt_flag   <= 1'b0;
      address_update_needed <= 1'b0;
      read_dir_flag         <= 1'b0;
      data_not_addr_flag    <= 1'b0;
      start_seen_flag       <= 1'b0;
      stop_seen_flag        <= 1'b0;
    end else if (!port_enable_bit) begin
      st_r                  <= ST_IDLE; // RQ25
      sda_low_r             <= 1'b0;
      hold_r                <= 1'b0;
      acking_r              <= 1'b0;
      ten_hi_ok_r           <= 1'b0;
      address_update_needed <= 1'b0;
      start_seen_flag       <= 1'b0; // RQ24
      stop_seen_flag        <= 1'b0;
      buffer_full_flag      <= 1'b0;
      if (overflow_clr)
        receive_overflow_flag <= 1'b0;
      if (irq_clr)
        port_interrupt_flag <= 1'b0;
    end else begin
      // Software side; hardware sets below win over these clears
      if (buf_rd)
        buffer_full_flag <= 1'b0; // RQ9
      if (overflow_clr)
        receive_overflow_flag <= 1'b0; // RQ9
      if (irq_clr)
        port_interrupt_flag <= 1'b0; // RQ15
      if (clock_release_wr)
        hold_r <= ~clock_release_bit; // RQ23
      if (own_address_wr && address_update_needed) begin
        // Low byte write releases at once; high byte restore only on a match
        if (addr_phase_r || hi_restore) begin
          address_update_needed <= 1'b0; // RQ11 RQ12
          hold_r                <= 1'b0;
        end
      end
      if (buf_wr && read_dir_flag) begin
        sh_r             <= buf_wdata; // RQ17
        rx_tx_buffer     <= buf_wdata;
        buffer_full_flag <= 1'b1;
      end
      if (start_det) begin
        start_seen_flag <= 1'b1; // RQ24
        stop_seen_flag  <= 1'b0;
        if (sp_irq)
          port_interrupt_flag <= 1'b1; // RQ22
        if (active) begin
          st_r         <= ST_RX; // RQ4
          cnt_r        <= 4'h0;
          addr_phase_r <= 1'b1;
          ten_lo_r     <= 1'b0;
          sda_low_r    <= 1'b0;
          read_dir_flag <= 1'b0;
        end
      end else if (stop_det) begin
        stop_seen_flag  <= 1'b1;
        start_seen_flag <= 1'b0;
        if (sp_irq)
          port_interrupt_flag <= 1'b1;
        st_r        <= ST_IDLE;
        sda_low_r   <= 1'b0;
        ten_hi_ok_r <= 1'b0;
      end else if (active) begin
        case (st_r)
          ST_RX: begin
            if (scl_rise) begin
              sh_r  <= byte_in; // RQ5
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              // Eighth falling edge: decide match and ack
              acking_r   <= 1'b0;
              ack_pend_r <= 1'b0;
              st_r       <= ST_ACK;
              if (addr_phase_r) begin
                if (!ten_mode && seven_match) begin
                  ack_pend_r <= 1'b1; // RQ6
                end else if (ten_mode && !ten_lo_r && hi_match &&
                             (!sh_r[0] || ten_hi_ok_r)) begin
                  ack_pend_r <= 1'b1; // RQ10 RQ13
                end else if (ten_mode && ten_lo_r && lo_match) begin
                  ack_pend_r <= 1'b1;
                end else begin
                  st_r <= ST_IDLE; // No match, ignore rest of frame
                end
              end else begin
                ack_pend_r <= 1'b1;
              end
              if (!(addr_phase_r && !(ten_mode ? (ten_lo_r ? lo_match : hi_match &&
                  (!sh_r[0] || ten_hi_ok_r)) : seven_match))) begin
                if (!buffer_full_flag && !receive_overflow_flag) begin
                  rx_tx_buffer     <= sh_r; // RQ7 RQ14
                  buffer_full_flag <= 1'b1;
                  sda_low_r        <= 1'b1;
                  acking_r         <= 1'b1;
                end else if (!addr_phase_r) begin
                  receive_overflow_flag <= 1'b1; // RQ8
                end
                data_not_addr_flag <= ~addr_phase_r;
                if (addr_phase_r && (!ten_mode || ten_lo_r || !sh_r[0]))
                  read_dir_flag <= ten_mode ? 1'b0 : sh_r[0]; // RQ14 RQ16
                if (addr_phase_r && ten_mode && !ten_lo_r && sh_r[0])
                  read_dir_flag <= 1'b1; // RQ13
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              // Ninth falling edge
              sda_low_r           <= 1'b0;
              cnt_r               <= 4'h0;
              port_interrupt_flag <= 1'b1; // RQ7 RQ8 RQ15
              st_r                <= ST_RX;
              if (addr_phase_r && ten_mode && !ten_lo_r && !sh_r[0]) begin
                ten_lo_r              <= 1'b1; // RQ11
                hi_bits_r             <= sh_r[2:1];
                address_update_needed <= 1'b1;
                hold_r                <= 1'b1;
              end else if (addr_phase_r && ten_mode && ten_lo_r) begin
                addr_phase_r          <= 1'b0; // RQ12
                ten_hi_ok_r           <= 1'b1;
                address_update_needed <= 1'b1;
                hold_r                <= 1'b1;
              end else if (read_dir_flag && acking_r) begin
                st_r  <= ST_TX; // RQ16
                hold_r <= 1'b1;
                addr_phase_r <= 1'b0;
              end else begin
                addr_phase_r <= 1'b0;
              end
              if (!acking_r && addr_phase_r)
                st_r <= ST_IDLE;
            end
          end
          ST_TX: begin
            // Bit 7 goes out with the load, while SCL is still held low
            if (buf_wr && cnt_r == 4'h0) begin
              sda_low_r <= ~buf_wdata[7]; // RQ18
              cnt_r     <= 4'h1;
            end else if (scl_fall && cnt_r != 4'h0) begin
              if (cnt_r == 4'h8) begin
                sda_low_r        <= 1'b0;
                buffer_full_flag <= 1'b0;
                st_r             <= ST_TACK;
              end else begin
                sh_r      <= {sh_r[6:0], 1'b0};
                sda_low_r <= ~sh_r[6]; // RQ18
                cnt_r     <= cnt_r + 4'h1;
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                ack_pend_r    <= 1'b0; // RQ19
                read_dir_flag <= 1'b0;
                data_not_addr_flag <= 1'b0;
                ten_hi_ok_r   <= 1'b0;
              end else begin
                ack_pend_r <= 1'b1;
              end
            end else if (scl_fall) begin
              port_interrupt_flag <= 1'b1; // RQ15
              if (ack_pend_r) begin
                st_r   <= ST_TX; // RQ19
                cnt_r  <= 4'h0;
                hold_r <= 1'b1;
              end else begin
                st_r <= ST_IDLE; // RQ19
              end
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain only, and only when the pins are left as inputs
  wire pins_ok = port_enable_bit & any_mode & scl_dir_in & sda_dir_in; // RQ3
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = pins_ok & active & hold_r; // RQ20 RQ23
  assign sda_oe  = pins_ok & active & sda_low_r;
  always @* clock_held = hold_r;
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the two-wire target port
`timescale 1ns/10ps
`include "tsp_defines.vh"
module tb;
  reg        mclk, rst, en, dirs, crb, crw, oaw, bwr, brd, ovc, irc, irq_d, a;
  reg  [3:0] mode;
  reg  [7:0] oa, bwd, mirror, got;
  reg  [7:0] notes[$];
  integer    mismatches, total_checks, seed, k;
  wire       scl_oe, sda_oe, m_scl, m_sda, full, ovf, irq, upd, rdir, dna, sts, sps, held;
  wire [7:0] rbuf;
  wire       scl = !(scl_oe | m_scl);
  wire       sda = !(sda_oe | m_sda);
  tsp_target DUT (
    .mclk(mclk), .rst(rst), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .scl_dir_in(dirs), .sda_dir_in(dirs),
    .port_enable_bit(en), .port_mode_select(mode), .clock_release_bit(crb),
    .clock_release_wr(crw), .own_address_register(oa), .own_address_wr(oaw),
    .buf_wdata(bwd), .buf_wr(bwr), .buf_rd(brd), .overflow_clr(ovc), .irq_clr(irc),
    .rx_tx_buffer(rbuf), .buffer_full_flag(full), .receive_overflow_flag(ovf),
    .port_interrupt_flag(irq), .address_update_needed(upd), .read_dir_flag(rdir),
    .data_not_addr_flag(dna), .start_seen_flag(sts), .stop_seen_flag(sps),
    .clock_held(held)
  );
  tsp_ctrl_model m (.scl(scl), .sda(sda), .scl_lo(m_scl), .sda_lo(m_sda));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input [63:0] nm, input [8:0] e, input [8:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  function [7:0] rnd(input integer u);
    integer v;
    begin
      v = $random(seed);
      rnd = v[7:0];
    end
  endfunction
  // Software pulse on {crw, oaw, bwr, brd, ovc, irc}
  task sw(input [5:0] p);
    begin
      @(posedge mclk) #1 {crw, oaw, bwr, brd, ovc, irc} = p;
      @(posedge mclk) #1 {crw, oaw, bwr, brd, ovc, irc} = 6'h00;
    end
  endtask
  // Refused bytes leave the buffer as it was
  task xfer(input [7:0] d, input reg ack_e, input reg irq_e);
    begin
      if (ack_e)
        mirror = d;
      if (irq_e)
        notes.push_back(mirror);
      m.wr_byte(d, a);
      check("ack", {8'h00, ack_e}, {8'h00, a});
      repeat (5) @(posedge mclk);
      if (!irq_e)
        check("noirq", 9'h000, {8'h00, irq});
      sw(6'h01);
    end
  endtask
  task tx_one;
    begin
      bwd = rnd(0);
      check("held", 9'h003, {7'h00, rdir, held});
      notes.push_back(bwd);
      fork
        m.rd_byte(1'b1, got);
        begin
          repeat (30) @(posedge mclk);
          sw(6'h04);
          sw(6'h08);
          crb = 1'b1;
          sw(6'h20);
          crb = 1'b0;
        end
      join
      check("txbyte", {1'b0, bwd}, {1'b0, got});
      repeat (5) @(posedge mclk);
      sw(6'h01);
      check("txend", 9'h000, {8'h00, rdir});
    end
  endtask
  always @(posedge mclk) begin
    irq_d <= irq;
    if (!rst && irq && !irq_d && notes.size() > 0)
      check("buf", {1'b0, notes.pop_front()}, {1'b0, rbuf});
  end
  initial begin
    #600000;
    mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    {en, dirs, crb, crw, oaw, bwr, brd, ovc, irc, irq_d} = 10'h000;
    rst = 1'b1;
    mode = `TSP_MODE_T7;
    oa = 8'hA8;
    bwd = 8'h00;
    mirror = 8'h00;
    mismatches = 0;
    total_checks = 0;
    seed = 33179;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    check("rst", 9'h000, {full, ovf, irq, upd, rdir, dna, sts, sps, held});
    en = 1'b1;
    repeat (4) @(posedge mclk);
    #1 dirs = 1'b1;
    for (k = 0; k < 2; k = k + 1) begin
      mode = k ? `TSP_MODE_T7_SP : `TSP_MODE_T7;
      if (k)
        notes.push_back(mirror);
      m.start;
      if (k)
        sw(6'h01);
      xfer(8'hA8, 1'b1, 1'b1);
      check("rdir", 9'h000, {8'h00, rdir});
      sw(6'h04);
      xfer(rnd(0), 1'b1, 1'b1);
      xfer(rnd(0), 1'b0, 1'b1);
      check("ovfull", 9'h003, {7'h00, ovf, full});
      sw(6'h04);
      xfer(rnd(0), 1'b0, 1'b1);
      sw(6'h02);
      check("ovclr", 9'h000, {7'h00, ovf, full});
      if (k)
        notes.push_back(mirror);
      m.stop;
      if (k)
        sw(6'h01);
      check("stop", 9'h001, {7'h00, sts, sps});
    end
    for (k = 0; k < 3; k = k + 1) begin
      mode = (k == 2) ? `TSP_MODE_CTRL : `TSP_MODE_T7;
      m.start;
      sw(6'h01);
      xfer((k == 0) ? {`TSP_GENCALL, 1'b0} : ((k == 1) ? 8'hAA : 8'hA8), 1'b0, 1'b0);
      m.stop;
      sw(6'h01);
    end
    mode = `TSP_MODE_T7;
    m.start;
    xfer(8'hA9, 1'b1, 1'b1);
    tx_one;
    m.stop;
    mode = `TSP_MODE_T10;
    oa = 8'hF4;
    m.start;
    xfer(8'hF4, 1'b1, 1'b1);
    check("upd1", 9'h003, {7'h00, upd, held});
    sw(6'h04);
    oa = 8'h3C;
    sw(6'h10);
    xfer(8'h3C, 1'b1, 1'b1);
    check("upd2", 9'h001, {8'h00, upd});
    sw(6'h04);
    oa = 8'hF4;
    sw(6'h10);
    check("upd3", 9'h000, {8'h00, upd});
    xfer(rnd(0), 1'b1, 1'b1);
    sw(6'h04);
    m.start;
    xfer(8'hF5, 1'b1, 1'b1);
    tx_one;
    m.stop;
    @(posedge mclk) #1 en = 1'b0;
    repeat (3) @(posedge mclk);
    check("off", 9'h000, {5'h00, sts, sps, full, upd});
    close_out;
  end
endmodule

// ===== testbench/tsp_ctrl_model.sv
// Behavioural two-wire bus controller that drives the target port
`timescale 1ns/10ps
module tsp_ctrl_model (
  // Wired bus levels
  input  wire scl,
  input  wire sda,
  // Pull-down requests
  output reg  scl_lo,
  output reg  sda_lo
);
  localparam real HP = 62.5;
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  // Hold after the fall so the target never sees data move with SCL high
  task bit_x(input reg b, output reg s);
    integer n;
    begin
      #20 sda_lo = !b;
      #(HP - 20) scl_lo = 1'b0;
      n = 0;
      while (scl !== 1'b1 && n < 4000) begin
        #10 n = n + 1;
      end
      #HP s = sda;
      scl_lo = 1'b1;
    end
  endtask
  task wr_byte(input [7:0] d, output reg ack);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_x(d[i], s);
      bit_x(1'b1, s);
      ack = !s;
    end
  endtask
  task rd_byte(input reg nack, output reg [7:0] d);
    integer i;
    reg     s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_x(1'b1, s);
        d[i] = s;
      end
      bit_x(nack, s);
    end
  endtask
  task start;
    begin
      #20 sda_lo = 1'b0;
      #HP scl_lo = 1'b0;
      #HP sda_lo = 1'b1;
      #HP scl_lo = 1'b1;
    end
  endtask
  task stop;
    begin
      #20 sda_lo = 1'b1;
      #HP scl_lo = 1'b0;
      #HP sda_lo = 1'b0;
      #HP;
    end
  endtask
endmodule

// ===== testbench/tsp_target_asserts.sv
// Concurrent checks on the two-wire target port
`timescale 1ns/10ps
`include "tsp_defines.vh"
module tsp_target_asserts (
  // Clock and reset
  input wire       mclk,
  input wire       rst,
  // Pins and control
  input wire       scl_in,
  input wire       scl_oe,
  input wire       sda_oe,
  input wire       scl_dir_in,
  input wire       sda_dir_in,
  input wire       port_enable_bit,
  input wire [3:0] port_mode_select,
  input wire       buf_rd,
  input wire       overflow_clr,
  input wire       clock_release_bit,
  input wire       clock_release_wr,
  // Status
  input wire       buffer_full_flag,
  input wire       receive_overflow_flag,
  input wire       port_interrupt_flag,
  input wire       read_dir_flag,
  input wire       start_seen_flag,
  input wire       stop_seen_flag,
  input wire       clock_held
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_ack;
    $rose(sda_oe) && !read_dir_flag;
  endsequence
  property p_off;
    !port_enable_bit [*2] |-> !scl_oe && !sda_oe && !start_seen_flag && !stop_seen_flag;
  endproperty
  property p_dir;
    (!scl_dir_in || !sda_dir_in) [*2] |-> !scl_oe && !sda_oe;
  endproperty
  property p_idle;
    (port_mode_select == `TSP_MODE_CTRL) [*2] |-> !sda_oe;
  endproperty
  property p_room;
    s_ack |-> !$past(buffer_full_flag) && !$past(receive_overflow_flag);
  endproperty
  property p_ack_len;
    s_ack |-> sda_oe [*4];
  endproperty
  property p_irq;
    s_ack |-> ##[4:30] port_interrupt_flag;
  endproperty
  property p_sda_low;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  property p_ovf;
    $fell(receive_overflow_flag) |-> $past(overflow_clr);
  endproperty
  property p_full;
    $fell(buffer_full_flag) |-> $past(buf_rd) || $past(read_dir_flag) || !$past(port_enable_bit);
  endproperty
  property p_hold;
    clock_held && clock_release_wr && clock_release_bit |=> !clock_held;
  endproperty
  property p_cond;
    !(start_seen_flag && stop_seen_flag);
  endproperty
  a_off:     assert property (p_off)     else $error("pins or flags live while off");
  a_dir:     assert property (p_dir)     else $error("pin driven while set as output");
  a_idle:    assert property (p_idle)    else $error("ack in controller mode");
  a_room:    assert property (p_room)    else $error("ack with full or overflow");
  a_ack_len: assert property (p_ack_len) else $error("ack pulse too short");
  a_irq:     assert property (p_irq)     else $error("no flag after ack");
  a_sda_low: assert property (p_sda_low) else $error("sda moved with scl high");
  a_ovf:     assert property (p_ovf)     else $error("overflow cleared by itself");
  a_full:    assert property (p_full)    else $error("full cleared without read");
  a_hold:    assert property (p_hold)    else $error("stretch not released");
  a_cond:    assert property (p_cond)    else $error("start and stop both set");
endmodule
bind tsp_target tsp_target_asserts u_chk (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .scl_dir_in(scl_dir_in), .sda_dir_in(sda_dir_in), .port_enable_bit(port_enable_bit),
  .port_mode_select(port_mode_select), .buf_rd(buf_rd), .overflow_clr(overflow_clr),
  .clock_release_bit(clock_release_bit), .clock_release_wr(clock_release_wr),
  .buffer_full_flag(buffer_full_flag), .receive_overflow_flag(receive_overflow_flag),
  .port_interrupt_flag(port_interrupt_flag), .read_dir_flag(read_dir_flag),
  .start_seen_flag(start_seen_flag), .stop_seen_flag(stop_seen_flag),
  .clock_held(clock_held)
);
